// file: hdl/csc_osc.sv
// phase-accumulator oscillator model with start-up stability count
`timescale 1ns/1ns
module csc_osc #(
    parameter logic [3:0] STABLE_TICKS = 4'h4
) (
    input wire logic aclk,
    input wire logic aresetn,
    csc_osc_if.osc   o
);
    import csc_pkg::*;

    logic [ACC_W:0]   sum;
    logic [ACC_W-1:0] acc_q;
    logic             tick_q;
    logic [3:0]       cnt_q;

    assign sum = {1'b0, acc_q} + {1'b0, o.step};

    // stopping the oscillator clears its phase so a restart begins cleanly
    always_ff @(posedge aclk) begin
        if (!aresetn || !o.run) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= sum[ACC_W-1:0];
            tick_q <= sum[ACC_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !o.run) begin
            cnt_q <= '0;
        end else if (tick_q && cnt_q != STABLE_TICKS) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign o.tick   = tick_q;
    assign o.stable = o.run && (cnt_q == STABLE_TICKS);
endmodule

// file: hdl/csc_osc_if.sv
// oscillator control and status bundle between control and oscillator model
`timescale 1ns/1ns
interface csc_osc_if;
    logic              run;
    logic [23:0]       step;
    logic              tick;
    logic              stable;
    modport ctrl (output run, output step, input tick, input stable);
    modport osc  (input run, input step, output tick, output stable);
endinterface

// file: hdl/csc_pkg.sv
// constants, field layout and types of the system clock source control
package csc_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned STARTUP_DELAY_NS = 10000;
    localparam int unsigned STARTUP_CYC      =
        (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DLY_W            = 10;
    localparam logic [DLY_W-1:0] STARTUP_LAST = DLY_W'(STARTUP_CYC - 1);

    localparam int unsigned ACC_W     = 24;
    localparam logic [23:0] HF_STEP   = 24'h147ae1;
    localparam logic [23:0] LF_STEP   = 24'h001451;
    localparam int unsigned TRIM_SHIFT = 14;
    localparam int unsigned TRIM_W    = 5;
    localparam logic [4:0]  TRIM_RST  = 5'h00;
    localparam logic [2:0]  SLEW_DONE = 3'h4;
    localparam logic [3:0]  HF_STABLE_TICKS = 4'h4;
    localparam logic [3:0]  LF_STABLE_TICKS = 4'h2;

    localparam logic [1:0]  FREQ_31K  = 2'h0;
    localparam logic [1:0]  FREQ_1M   = 2'h1;
    localparam logic [1:0]  FREQ_4M   = 2'h2;
    localparam logic [1:0]  FREQ_8M   = 2'h3;
    localparam logic [1:0]  FREQ_RST  = FREQ_1M;
    localparam logic [2:0]  POST_1M_LAST = 3'h7;

    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0]  OSC_CTRL_OFS  = 4'h0;
    localparam logic [3:0]  OSC_TUNE_OFS  = 4'h4;
    localparam int unsigned FREQ_SEL_LSB  = 4;
    localparam int unsigned HF_STABLE_BIT = 2;
    localparam int unsigned LF_STABLE_BIT = 1;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} csc_pwr_t;
endpackage

// file: hdl/csc_top.sv
// system clock source control with axi4-lite register access
// Function
// R1 - external clock input drives the system clock when source select is one
// R2 - internal oscillators drive the system clock when source select is zero
// R3 - outside party supplies a logic clock, DC to 20 MHz, on the input pin
// R4 - stopped external clock halts the block with all state kept
// R5 - frequency select: 11 8 MHz, 10 4 MHz, 01 1 MHz default, 00 31 kHz
// R6 - trim only affects the high-frequency oscillator, never the low one
// R7 - trim is 5-bit two's complement, resets to zero
// R8 - trim change slews gradually, settling within eight base cycles
// R9 - system keeps running during a trim slew, no completion flag
// R10 - stable flags read one only while their oscillator runs stable
// R11 - output enabled drives selected clock divided by four, pin reads zero
// R12 - output disable releases the pin for general purpose use
// R13 - about 10 us hold-off after power-on or wake, any source
// R14 - wake hold-off applies even if the oscillator kept running
// R15 - unimplemented register bits read as zero
// R16 - 8 MHz high oscillator, postscaler for 4 and 1 MHz, separate 31 kHz
// R17 - frequency select changes switch the clock without runt pulses
`timescale 1ns/1ns
module csc_top (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [csc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [csc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              clock_source_select,
    input  wire logic              clock_output_disable,
    input  wire logic              clock_input_pin,
    input  wire logic              sleep_req,
    input  wire logic              periph_keeps_osc,
    output logic                   sys_clk_en,
    output logic                   core_run,
    input  wire logic              clock_output_pin_i,
    output logic                   clock_output_pin_o,
    output logic                   clock_output_pin_oe,
    output logic                   gpio_pin_read
);
    import csc_pkg::*;

    csc_osc_if hf_if ();
    csc_osc_if lf_if ();

    csc_pwr_t               state_q;
    logic [DLY_W-1:0]       delay_q;
    logic [1:0]             freq_sel_q;
    logic [1:0]             freq_act_q;
    logic [TRIM_W-1:0]      trim_q;
    logic signed [ACC_W:0]  from_q;
    logic signed [ACC_W:0]  to_q;
    logic signed [ACC_W:0]  diff;
    logic signed [ACC_W:0]  cur_step;
    logic [2:0]             slew_k_q;
    logic [2:0]             post_q;
    logic                   clk_in_q;
    logic                   ext_tick_q;
    logic                   int_tick;
    logic                   src_tick;
    logic                   osc_on;
    logic                   cko_half_q;
    logic                   cko_q;
    logic                   gpio_q;
    logic                   aw_q;
    logic                   w_q;
    logic [ADDR_W-1:0]      awaddr_q;
    logic [7:0]             wdata_q;
    logic                   wstrb0_q;
    logic                   commit;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rdata_q;

    function automatic logic signed [ACC_W:0] trim_target(
        input logic [TRIM_W-1:0] t
    );
        logic signed [ACC_W:0] ext;
        ext = $signed({{(ACC_W+1-TRIM_W){t[TRIM_W-1]}}, t});
        return $signed({1'b0, HF_STEP}) + (ext <<< TRIM_SHIFT);
    endfunction

    csc_osc #(.STABLE_TICKS(HF_STABLE_TICKS)) u_hf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .o       (hf_if.osc)
    );

    csc_osc #(.STABLE_TICKS(LF_STABLE_TICKS)) u_lf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .o       (lf_if.osc)
    );

    // hold-off after reset release or wake, counted in aclk cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_HOLD;
            delay_q <= '0;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    if (delay_q == STARTUP_LAST) begin
                        state_q <= ST_RUN;                         // [R13]
                    end else begin
                        delay_q <= delay_q + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (sleep_req) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // memory bias needs settling even with a live clock
                    if (!sleep_req) begin
                        state_q <= ST_HOLD;                        // [R14]
                        delay_q <= '0;
                    end
                end
            endcase
        end
    end

    assign core_run = (state_q == ST_RUN);
    assign osc_on   = (state_q != ST_SLEEP) || periph_keeps_osc;

    // only the selected internal oscillator runs, saving power
    assign hf_if.run = osc_on && !clock_source_select
                       && (freq_act_q != FREQ_31K);                // [R16]
    assign lf_if.run = osc_on && !clock_source_select
                       && (freq_act_q == FREQ_31K);
    assign lf_if.step = LF_STEP;                                    // [R6]

    // trim slews in quarter steps per base tick, done in four ticks
    assign diff = to_q - from_q;
    always_comb begin
        unique case (slew_k_q)
            3'h0:    cur_step = from_q;
            3'h1:    cur_step = from_q + (diff >>> 2);
            3'h2:    cur_step = from_q + (diff >>> 1);
            3'h3:    cur_step = from_q + (diff >>> 1) + (diff >>> 2);
            default: cur_step = to_q;                               // [R8]
        endcase
    end
    assign hf_if.step = cur_step[ACC_W-1:0];                        // [R6]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            from_q   <= trim_target(TRIM_RST);
            to_q     <= trim_target(TRIM_RST);
            slew_k_q <= SLEW_DONE;
        end else if (commit && wstrb0_q && awaddr_q == OSC_TUNE_OFS) begin
            from_q   <= cur_step;
            to_q     <= trim_target(wdata_q[TRIM_W-1:0]);           // [R7]
            slew_k_q <= '0;
        end else if (hf_if.tick && slew_k_q != SLEW_DONE) begin
            slew_k_q <= slew_k_q + 3'h1;                            // [R9]
        end
    end

    // postscaler derives 4 and 1 MHz from the 8 MHz oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn || !hf_if.run) begin
            post_q <= '0;
        end else if (hf_if.tick) begin
            post_q <= post_q + 3'h1;                                // [R16]
        end
    end

    always_comb begin
        unique case (freq_act_q)
            FREQ_8M:  int_tick = hf_if.tick;                        // [R5]
            FREQ_4M:  int_tick = hf_if.tick && post_q[0];
            FREQ_1M:  int_tick = hf_if.tick && post_q == POST_1M_LAST;
            FREQ_31K: int_tick = lf_if.tick;
        endcase
    end

    // input pin is synchronous; a stopped pin simply yields no ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_in_q   <= 1'b0;
            ext_tick_q <= 1'b0;
        end else begin
            clk_in_q   <= clock_input_pin;
            ext_tick_q <= clock_input_pin && !clk_in_q;             // [R4]
        end
    end

    assign src_tick = clock_source_select ? ext_tick_q : int_tick; // [R1] [R2]
    assign sys_clk_en = core_run && src_tick;                        // [R13]

    // new selection takes effect on a period boundary of the old one, or at once while the external source is selected or the core is not running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_act_q <= FREQ_RST;
        end else if (clock_source_select || !core_run || int_tick) begin
            freq_act_q <= freq_sel_q;                               // [R17]
        end
    end

    // output toggles every second tick: a full period is four ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cko_half_q <= 1'b0;
            cko_q      <= 1'b0;
        end else if (src_tick) begin
            cko_half_q <= !cko_half_q;
            if (cko_half_q) begin
                cko_q <= !cko_q;                                    // [R11]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpio_q <= 1'b0;
        end else begin
            gpio_q <= clock_output_disable && clock_output_pin_i; // [R11] [R12]
        end
    end

    assign clock_output_pin_o  = cko_q;
    assign clock_output_pin_oe = !clock_output_disable;             // [R12]
    assign gpio_pin_read       = gpio_q;

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready  = !w_q && !bvalid_q;
    assign commit        = aw_q && w_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q     <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (commit) begin
            aw_q     <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q      <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_q      <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
        end else if (commit) begin
            w_q      <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_sel_q <= FREQ_RST;                                 // [R5]
            trim_q     <= TRIM_RST;                                 // [R7]
        end else if (commit && wstrb0_q) begin
            if (awaddr_q == OSC_CTRL_OFS) begin
                freq_sel_q <= wdata_q[FREQ_SEL_LSB +: 2];
            end
            if (awaddr_q == OSC_TUNE_OFS) begin
                trim_q <= wdata_q[TRIM_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awaddr_q == OSC_CTRL_OFS || awaddr_q == OSC_TUNE_OFS)
                        ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // axi4-lite read, one outstanding; unused bits stay zero
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;                                         // [R15]
            if (s_axi_araddr == OSC_CTRL_OFS) begin
                rdata_q[FREQ_SEL_LSB +: 2] <= freq_sel_q;
                rdata_q[HF_STABLE_BIT]     <= hf_if.stable;         // [R10]
                rdata_q[LF_STABLE_BIT]     <= lf_if.stable;
            end else if (s_axi_araddr == OSC_TUNE_OFS) begin
                rdata_q[TRIM_W-1:0] <= trim_q;
            end else begin
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ext_source;
        clock_source_select && core_run && ext_tick_q |-> sys_clk_en;
    endproperty
    a_ext_source: assert property (p_ext_source)                   // [R1]
        else $error("external edge did not clock the system");

    property p_int_source;
        !clock_source_select && !ext_tick_q |->
            (sys_clk_en == (core_run && int_tick));
    endproperty
    a_int_source: assert property (p_int_source)                   // [R2]
        else $error("internal tick not routed to system clock");

    property p_ext_halt;
        clock_source_select && !ext_tick_q |-> !sys_clk_en;
    endproperty
    a_ext_halt: assert property (p_ext_halt)                       // [R4]
        else $error("system clock ran with external clock stopped");

    property p_reset_values;
        $rose(aresetn) |-> freq_sel_q == FREQ_1M && trim_q == 5'h00;
    endproperty
    a_reset_values: assert property (p_reset_values)               // [R5]
        else $error("wrong reset value of select or trim");

    property p_lf_select;
        !clock_source_select && freq_act_q == FREQ_31K |->
            !hf_if.run && (int_tick == lf_if.tick);
    endproperty
    a_lf_select: assert property (p_lf_select)                     // [R16]
        else $error("31 kHz selection not from low oscillator");

    property p_slew_bound;
        slew_k_q != SLEW_DONE && hf_if.tick && !commit |=>
            slew_k_q == $past(slew_k_q) + 3'h1;
    endproperty
    a_slew_bound: assert property (p_slew_bound)                   // [R8]
        else $error("trim slew did not advance on a base tick");

    property p_stable_flags;
        (hf_if.stable |-> hf_if.run) and (lf_if.stable |-> lf_if.run);
    endproperty
    a_stable_flags: assert property (p_stable_flags)               // [R10]
        else $error("stable flag set with oscillator stopped");

    sequence s_out_enabled;
        !clock_output_disable ##1 !clock_output_disable;
    endsequence
    property p_clock_output_pin_on;
        s_out_enabled |-> clock_output_pin_oe && !gpio_pin_read;
    endproperty
    a_clock_output_pin_on: assert property (p_clock_output_pin_on)                     // [R11]
        else $error("clock output pin not driven or reads nonzero");

    property p_clock_output_pin_off;
        clock_output_disable |-> !clock_output_pin_oe;
    endproperty
    a_clock_output_pin_off: assert property (p_clock_output_pin_off)                   // [R12]
        else $error("clock output still driving when disabled");

    property p_holdoff;
        core_run && !$past(core_run) |-> $past(delay_q) == STARTUP_LAST;
    endproperty
    a_holdoff: assert property (p_holdoff)                         // [R13]
        else $error("run started before the start-up delay");

    sequence s_wake;
        state_q == ST_SLEEP ##1 state_q != ST_SLEEP;
    endsequence
    property p_wake_delay;
        s_wake |-> state_q == ST_HOLD && delay_q == '0;
    endproperty
    a_wake_delay: assert property (p_wake_delay)                   // [R14]
        else $error("wake skipped the start-up delay");

    property p_reserved_zero;
        s_axi_arvalid && s_axi_arready |=> s_axi_rdata[31:6] == 26'h0
            && (s_axi_rdata[3] == 1'b0 && s_axi_rdata[0] == 1'b0
                || $past(s_axi_araddr) != OSC_CTRL_OFS)
            && (s_axi_rdata[5] == 1'b0 || $past(s_axi_araddr) != OSC_TUNE_OFS);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)             // [R15]
        else $error("unimplemented bits read nonzero");

    property p_glitchless;
        !$past(clock_source_select) && $past(core_run)
            && freq_act_q != $past(freq_act_q) |-> $past(int_tick);
    endproperty
    a_glitchless: assert property (p_glitchless)                   // [R17]
        else $error("frequency switched mid period");
endmodule

// file: verification/csc_ext_src.sv
// external clock source model driving the clock input pin
`timescale 1ns/1ns
module csc_ext_src (
    input  wire logic       aclk,
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            clk_pin
);
    logic [7:0] cnt_q;
    // stands low between bursts; half >= 3 keeps it at or below 20 MHz
    always_ff @(posedge aclk) begin
        if (!run) begin
            cnt_q   <= 8'h00;
            clk_pin <= 1'b0;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q   <= 8'h00;
            clk_pin <= !clk_pin;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// file: verification/system_clock_source_control_tb.sv
// self-checking bench for the system clock source control
`timescale 1ns/1ns
module system_clock_source_control_tb;
    import csc_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
    logic [31:0] rnd = 32'hb8fd6a72;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        clock_source_select = 0, clock_output_disable = 0;
    logic        sleep_req = 0, periph_keeps_osc = 0, ext_run = 0;
    logic        ext_pin = 0, clock_input_pin, sys_clk_en, core_run;
    logic        clock_output_pin_i, clock_output_pin_o;
    logic        clock_output_pin_oe, gpio_pin_read, pin_q;
    logic [7:0]  half = 8'h05;
    int          n_mismatch = 0, checks = 0, k, t, g;

    always #5 aclk = !aclk;
    // the pin wire: the design wins while it drives, else outside noise
    assign clock_output_pin_i = clock_output_pin_oe ? clock_output_pin_o
                                                    : ext_pin;
    always @(posedge aclk) begin
        rnd     <= lfsr(rnd);
        ext_pin <= rnd[7];
        pin_q   <= clock_output_pin_i;
    end

    csc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_source_select,
        .clock_output_disable, .clock_input_pin, .sleep_req,
        .periph_keeps_osc, .sys_clk_en, .core_run, .clock_output_pin_i,
        .clock_output_pin_o, .clock_output_pin_oe, .gpio_pin_read);
    csc_ext_src src (.aclk, .run(ext_run), .half,
        .clk_pin(clock_input_pin));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // ticks over n cycles of an accumulator step, after a postscaler
    function automatic int exp_t(input longint st, input int n, input int dv);
        return int'((longint'(n) * st) >> 24) / dv;
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checks++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask
    task automatic near(input string nm, input int e, input int s,
                        input int tol);
        checks++;
        if (s < e - tol || s > e + tol) begin
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
            n_mismatch++;
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 2000) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] w);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 2000; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask
    // counts system ticks and clock output edges over n cycles
    task automatic win(input int n);
        logic p;
        t = 0;
        g = 0;
        p = clock_output_pin_o;
        repeat (n) begin
            @(posedge aclk);
            if (sys_clk_en === 1'b1) t++;
            if (clock_output_pin_o !== p) g++;
            p = clock_output_pin_o;
        end
    endtask
    task automatic wake();
        for (k = 0; k < 2000 && core_run !== 1'b1; k++) @(posedge aclk);
        tmo(k);
        near("startup", 1001, k, 3);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wake();
        rd(OSC_CTRL_OFS);
        chk("ctrl_reset", 32'h14, d);
        rd(OSC_TUNE_OFS);
        chk("tune_reset", 32'h0, d);
        rd(4'h8);
        chk("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(4'hc, 32'hff);
        chk("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        repeat (8) begin
            v = rnd;
            wr(OSC_TUNE_OFS, v);
            rd(OSC_TUNE_OFS);
            chk("tune_rw", {27'h0, v[4:0]}, d);
            v = rnd;
            wr(OSC_CTRL_OFS, v);
            rd(OSC_CTRL_OFS);
            chk("ctrl_rw", {26'h0, v[5:4], 4'h0}, d & 32'hfffffff9);
        end
        wr(OSC_TUNE_OFS, 32'h0);
        for (int c = 3; c >= 1; c--) begin
            wr(OSC_CTRL_OFS, 32'(c << 4));
            repeat (3500) @(posedge aclk);
            win(2000);
            near("ticks", exp_t(HF_STEP, 2000,
                 c == 3 ? 1 : c == 2 ? 2 : 8), t, 3);
            near("clock_output_pin", t / 2, g, 2);
            rd(OSC_CTRL_OFS);
            chk("hf_stable", 32'h1, {31'h0, d[2]});
        end
        wr(OSC_CTRL_OFS, 32'h30);
        for (int i = 0; i < 2; i++) begin
            wr(OSC_TUNE_OFS, i ? 32'h10 : 32'h0f);
            repeat (120) @(posedge aclk);
            win(2000);
            near("trim", exp_t(longint'(HF_STEP) + (i ? -262144 : 245760),
                 2000, 1), t, 3);
        end
        wr(OSC_TUNE_OFS, 32'h0f);
        wr(OSC_CTRL_OFS, 32'h0);
        repeat (100) @(posedge aclk);
        win(7000);
        near("lf_ticks", exp_t(LF_STEP, 7000, 1), t, 1);
        rd(OSC_CTRL_OFS);
        chk("lf_stable", 32'h2, d & 32'h32);
        wr(OSC_CTRL_OFS, 32'h30);
        for (int i = 1; i >= 0; i--) begin
            @(posedge aclk);
            clock_output_disable <= i[0];
            repeat (3) @(posedge aclk);
            chk("pin_oe", 32'(!i), 32'(clock_output_pin_oe));
            repeat (16) begin
                @(posedge aclk);
                chk("gpio_read", i && pin_q, gpio_pin_read);
            end
        end
        @(posedge aclk);
        clock_source_select <= 1'b1;
        ext_run <= 1'b1;
        repeat (50) @(posedge aclk);
        win(1000);
        near("ext_ticks", 100, t, 2);
        @(posedge aclk);
        ext_run <= 1'b0;
        repeat (20) @(posedge aclk);
        win(300);
        chk("ext_stopped", 32'h0, 32'(t + g));
        chk("run_held", 32'h1, {31'h0, core_run});
        s_axi_wstrb <= 4'h0;
        wr(OSC_TUNE_OFS, 32'h1f);
        s_axi_wstrb <= 4'hf;
        rd(OSC_TUNE_OFS);
        chk("tune_kept", 32'h0f, d);
        @(posedge aclk);
        half <= 8'h08;
        ext_run <= 1'b1;
        repeat (50) @(posedge aclk);
        win(1600);
        near("ext_resume", 100, t, 2);
        @(posedge aclk);
        clock_source_select <= 1'b0;
        periph_keeps_osc <= 1'b1;
        sleep_req <= 1'b1;
        repeat (50) @(posedge aclk);
        chk("asleep", 32'h0, {31'h0, core_run});
        sleep_req <= 1'b0;
        wake();
        print_verdict();
    end
endmodule
